// ---- clk_ctrl_consts.svh ----
// constants of the clock source and pll control register block
// assumes byte addresses on a 12-bit apb address, 32-bit data
// How it works
// - writing one to a disable bit stops that peripheral clock; zero does nothing
// - peripheral status bits 2 to 31 show which peripheral clocks run
// - with oscillator enabled, stable flag rises only after start-up interval
// - start-up interval is the start-up count times eight slow clock cycles
// - bypass sets the stable flag at once, with no start-up wait
// - clearing enable and bypass together clears the stable flag
// - frequency field counts main clock cycles over 16 slow clock periods
// - measurement ready reads one only after oscillator enabled or bypassed and count valid
// - divider 0 gives no output, 1 bypasses, 2 to 255 divide
// - after each pll write, wait settle count slow cycles, then set lock
// - multiplier zero shuts pll down; otherwise output is input times value plus one
// - usb ratio 00 passes, 01 halves, 10 quarters, 11 reserved
// - master source 00 slow, 01 main, 11 pll, 10 reserved
// - master scaler code divides by two to the code, 111 reserved
// - each programmable output has its own source field, same coding
// - writing one to an enable bit starts that peripheral clock; zero does nothing
// - status bit 0 reads one once the main oscillator is stable
// - status bit 2 reads one once the pll is locked
// - each programmable output has its own three-bit scaler code
`ifndef CLK_CTRL_CONSTS_SVH
`define CLK_CTRL_CONSTS_SVH
`define OFF_PCER      12'h010
`define OFF_PCDR      12'h014
`define OFF_PCSR      12'h018
`define OFF_MOR       12'h020
`define OFF_MCFR      12'h024
`define OFF_PLLR      12'h02C
`define OFF_MCKR      12'h030
`define OFF_PCK_BASE  12'h040
`define OFF_SR        12'h068
`define WORD_BYTES    12'h004
`define PCK_NUM       3
`define PERIPH_MASK   32'hFFFFFFFC
`define MOR_EN_BIT    0
`define MOR_BYP_BIT   1
`define MOR_CNT_HI    15
`define MOR_CNT_LO    8
`define PLLR_MASK     32'h37FFFFFF
`define PLLR_RESET    32'h00003F00
`define PLL_DIV_HI    7
`define PLL_DIV_LO    0
`define PLL_CNT_HI    13
`define PLL_CNT_LO    8
`define PLL_OUT_HI    15
`define PLL_OUT_LO    14
`define PLL_MUL_HI    26
`define PLL_MUL_LO    16
`define PLL_USB_HI    29
`define PLL_USB_LO    28
`define CFG_HI        4
`define OSC_SHIFT     3
`define TMR_W         11
`define TMR_ZERO      11'h000
`define TMR_ONE       11'h001
`define MEAS_LAST     4'hF
`define WIN_ONE       4'h1
`define FREQ_MAX      16'hFFFF
`define FREQ_ONE      16'h0001
`endif

// ---- clk_ctrl_pkg.sv ----
// types of the clock source and pll control register block
// assumes nothing of its surroundings
`default_nettype none
package clk_ctrl_pkg;
  // frequency measurement states, gray along idle, run, done
  typedef enum logic [1:0] {
    MEAS_IDLE = 2'h0,
    MEAS_RUN  = 2'h1,
    MEAS_DONE = 2'h3
  } meas_state_e;
endpackage
`default_nettype wire

// ---- tick_timer_if.sv ----
// link between the control block and one slow clock interval timer
// assumes the user side drives start, tick and limit on pclk
`timescale 1ns/100ps
`default_nettype none
`include "clk_ctrl_consts.svh"
interface tick_timer_if;
  logic              start;
  logic              tick;
  logic [`TMR_W-1:0] limit;
  logic              done;
  modport user  (output start, output tick, output limit, input done);
  modport timer (input start, input tick, input limit, output done);
endinterface
`default_nettype wire

// ---- level_sync.sv ----
// three-stage synchroniser with agreement filter and rising-edge pulse
// assumes async_in comes from outside the pclk domain
`timescale 1ns/100ps
`default_nettype none
module level_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic async_in,
  output logic      rise
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  // chain, only s2 reads s1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // level changes once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_q <= 1'b0;
      rise  <= 1'b0;
    end else begin
      if (s2_q == s3_q) begin
        lvl_q <= s3_q;
      end
      rise <= (s2_q == s3_q) & s3_q & ~lvl_q;
    end
  end
endmodule
`default_nettype wire

// ---- slow_tick_timer.sv ----
// counts a loaded number of slow ticks and then raises done
// assumes start is a one-cycle pulse and tick a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none
`include "clk_ctrl_consts.svh"
module slow_tick_timer (
  input  wire logic  pclk,
  input  wire logic  presetn,
  tick_timer_if.timer tif
);
  logic [`TMR_W-1:0] cnt_q;
  logic              busy_q;
  logic              done_q;
  assign tif.done = done_q;
  // start restarts the count; a zero limit is done at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= `TMR_ZERO;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (tif.start) begin
      cnt_q  <= tif.limit;
      busy_q <= (tif.limit != `TMR_ZERO);
      done_q <= (tif.limit == `TMR_ZERO);
    end else if (busy_q && tif.tick) begin
      cnt_q <= cnt_q - `TMR_ONE;
      if (cnt_q == `TMR_ONE) begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- clock_source_pll_control_regs.sv ----
// clock generator control: peripheral gating, oscillator, frequency count, pll, master and output clocks
// assumes an apb master on pclk and slow and main clocks arriving as asynchronous pins
`timescale 1ns/100ps
`default_nettype none
`include "clk_ctrl_consts.svh"
module clock_source_pll_control_regs (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        slow_clk_in,
  input  wire logic        main_clk_in,
  output logic      [31:0] periph_clk_run,
  output logic             main_osc_enable,
  output logic             xtal_bypass,
  output logic             main_osc_stable,
  output logic             pll_run,
  output logic      [7:0]  pll_in_div,
  output logic      [10:0] pll_feedback_factor,
  output logic      [1:0]  pll_range,
  output logic      [1:0]  usb_clock_ratio,
  output logic      [1:0]  mck_source,
  output logic      [2:0]  mck_clock_scaler_code,
  output logic      [14:0] prog_clk_cfg
);
  logic                    acc;
  logic                    wr_en;
  logic                    hit;
  logic [31:0]             rd_data;
  wire  [`PCK_NUM-1:0]     hit_pck;
  wire  [5*`PCK_NUM-1:0]   pck_cfg_w;
  logic [7:0]              osc_cnt_q;
  logic [31:0]             pll_q;
  logic [4:0]              mckr_q;
  logic [4:0]              pck_q [`PCK_NUM];
  logic                    lock_q;
  logic                    valid_q;
  logic [15:0]             freq_q;
  logic [15:0]             mcount_q;
  logic [3:0]              win_q;
  logic                    slow_tick;
  logic                    main_rise;
  logic                    wr_mor;
  logic                    wr_pll;
  clk_ctrl_pkg::meas_state_e meas_q;

  tick_timer_if osc_tif ();
  tick_timer_if pll_tif ();

  // pin inputs through three-stage synchronisers
  level_sync u_slow_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (slow_clk_in),
    .rise     (slow_tick)
  );
  level_sync u_main_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (main_clk_in),
    .rise     (main_rise)
  );

  // apb phases: answer one cycle into the access phase
  assign acc    = psel & penable & ~pready;
  assign wr_en  = psel & penable & pready & pwrite;
  assign wr_mor = wr_en & (paddr == `OFF_MOR);
  assign wr_pll = wr_en & (paddr == `OFF_PLLR);

  // interval timers for oscillator start-up and pll settle
  assign osc_tif.start = wr_mor & pwdata[`MOR_EN_BIT] & ~main_osc_enable;
  assign osc_tif.tick  = slow_tick;
  assign osc_tif.limit = {pwdata[`MOR_CNT_HI:`MOR_CNT_LO], `OSC_SHIFT'(0)};
  assign pll_tif.start = wr_pll;
  assign pll_tif.tick  = slow_tick;
  assign pll_tif.limit = `TMR_W'(pwdata[`PLL_CNT_HI:`PLL_CNT_LO]);
  slow_tick_timer u_osc_tmr (
    .pclk    (pclk),
    .presetn (presetn),
    .tif     (osc_tif.timer)
  );
  slow_tick_timer u_pll_tmr (
    .pclk    (pclk),
    .presetn (presetn),
    .tif     (pll_tif.timer)
  );

  // read decode; write-only enable and disable words read zero
  always_comb begin
    rd_data = 32'h0;
    hit     = 1'b1;
    case (paddr)
      `OFF_PCER, `OFF_PCDR: begin
        rd_data = 32'h0;
      end
      `OFF_PCSR: begin
        rd_data = periph_clk_run;
      end
      `OFF_MOR: begin
        rd_data = {16'h0, osc_cnt_q, 6'h0, xtal_bypass, main_osc_enable};
      end
      `OFF_MCFR: begin
        rd_data = {15'h0, valid_q, freq_q};
      end
      `OFF_PLLR: begin
        rd_data = pll_q;
      end
      `OFF_MCKR: begin
        rd_data = {27'h0, mckr_q};
      end
      `OFF_SR: begin
        rd_data = {28'h0, 1'b1, lock_q, 1'b0, main_osc_stable};
      end
      default: begin
        hit = |hit_pck;
        for (int k = 0; k < `PCK_NUM; k++) begin
          if (hit_pck[k]) begin
            rd_data = {27'h0, pck_q[k]};
          end
        end
      end
    endcase
  end

  // bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= acc;
      pslverr <= acc & ~hit;
      if (acc) begin
        prdata <= rd_data;
      end
    end
  end

  // peripheral clock gating, bits 1:0 never change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_clk_run <= 32'h0;
    end else if (wr_en && paddr == `OFF_PCER) begin
      periph_clk_run <= periph_clk_run | (pwdata & `PERIPH_MASK);
    end else if (wr_en && paddr == `OFF_PCDR) begin
      periph_clk_run <= periph_clk_run & ~(pwdata & `PERIPH_MASK);
    end
  end

  // oscillator control word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_osc_enable <= 1'b0;
      xtal_bypass     <= 1'b0;
      osc_cnt_q       <= 8'h0;
    end else if (wr_mor) begin
      main_osc_enable <= pwdata[`MOR_EN_BIT];
      xtal_bypass     <= pwdata[`MOR_BYP_BIT];
      osc_cnt_q       <= pwdata[`MOR_CNT_HI:`MOR_CNT_LO];
    end
  end

  // stable flag: bypass at once, enable after the timer, neither clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_osc_stable <= 1'b0;
    end else begin
      main_osc_stable <= xtal_bypass | (main_osc_enable & osc_tif.done & ~osc_tif.start);
    end
  end

  // frequency measurement over sixteen slow periods, one shot per enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_q   <= clk_ctrl_pkg::MEAS_IDLE;
      win_q    <= 4'h0;
      mcount_q <= 16'h0;
      freq_q   <= 16'h0;
      valid_q  <= 1'b0;
    end else if (!main_osc_enable && !xtal_bypass) begin
      meas_q  <= clk_ctrl_pkg::MEAS_IDLE;
      valid_q <= 1'b0;
    end else begin
      case (meas_q)
        clk_ctrl_pkg::MEAS_IDLE: begin
          if (main_osc_stable && slow_tick) begin
            meas_q   <= clk_ctrl_pkg::MEAS_RUN;
            win_q    <= 4'h0;
            mcount_q <= 16'h0;
          end
        end
        clk_ctrl_pkg::MEAS_RUN: begin
          if (main_rise && mcount_q != `FREQ_MAX) begin
            mcount_q <= mcount_q + `FREQ_ONE;
          end
          if (slow_tick) begin
            win_q <= win_q + `WIN_ONE;
            if (win_q == `MEAS_LAST) begin
              meas_q  <= clk_ctrl_pkg::MEAS_DONE;
              freq_q  <= mcount_q;
              valid_q <= 1'b1;
            end
          end
        end
        clk_ctrl_pkg::MEAS_DONE: begin
          meas_q <= clk_ctrl_pkg::MEAS_DONE;
        end
        default: begin
          meas_q <= clk_ctrl_pkg::MEAS_IDLE;
        end
      endcase
    end
  end

  // pll word and lock flag, lock drops on every write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_q  <= `PLLR_RESET;
      lock_q <= 1'b0;
    end else begin
      if (wr_pll) begin
        pll_q <= pwdata & `PLLR_MASK;
      end
      lock_q <= pll_tif.done & ~wr_pll;
    end
  end

  // pll field outputs; run only with nonzero divider and multiplier
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_run             <= 1'b0;
      pll_in_div          <= 8'h0;
      pll_feedback_factor <= 11'h0;
      pll_range           <= 2'h0;
      usb_clock_ratio     <= 2'h0;
    end else begin
      pll_run             <= (pll_q[`PLL_DIV_HI:`PLL_DIV_LO] != 8'h0) &
                             (pll_q[`PLL_MUL_HI:`PLL_MUL_LO] != 11'h0);
      pll_in_div          <= pll_q[`PLL_DIV_HI:`PLL_DIV_LO];
      pll_feedback_factor <= pll_q[`PLL_MUL_HI:`PLL_MUL_LO];
      pll_range           <= pll_q[`PLL_OUT_HI:`PLL_OUT_LO];
      usb_clock_ratio     <= pll_q[`PLL_USB_HI:`PLL_USB_LO];
    end
  end

  // master clock selection and scaler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mckr_q <= 5'h0;
    end else if (wr_en && paddr == `OFF_MCKR) begin
      mckr_q <= pwdata[`CFG_HI:0];
    end
  end
  assign mck_source            = mckr_q[1:0];
  assign mck_clock_scaler_code = mckr_q[4:2];

  // programmable output words, one per output
  for (genvar k = 0; k < `PCK_NUM; k++) begin : g_pck
    assign hit_pck[k] = (paddr == (`OFF_PCK_BASE + 12'(k) * `WORD_BYTES));
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pck_q[k] <= 5'h0;
      end else if (wr_en && hit_pck[k]) begin
        pck_q[k] <= pwdata[`CFG_HI:0];
      end
    end
    assign pck_cfg_w[k*5 +: 5] = pck_q[k];
  end
  // one driver for the whole output word, each slice straight from its flop
  assign prog_clk_cfg = pck_cfg_w;

  // helper: slow ticks seen since oscillator start, frozen at done
  logic [`TMR_W-1:0] osc_ticks_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_ticks_q <= `TMR_ZERO;
    end else if (osc_tif.start) begin
      osc_ticks_q <= `TMR_ZERO;
    end else if (slow_tick && !osc_tif.done) begin
      osc_ticks_q <= osc_ticks_q + `TMR_ONE;
    end
  end

  property p_disable_bits;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == `OFF_PCDR) |=> ((periph_clk_run & $past(pwdata) & `PERIPH_MASK) == 32'h0);
  endproperty
  a_disable_bits: assert property (p_disable_bits) else $error("disable write left a clock running");

  property p_enable_bits;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == `OFF_PCER) |=>
        ((periph_clk_run & $past(pwdata) & `PERIPH_MASK) == ($past(pwdata) & `PERIPH_MASK))
        && (periph_clk_run[1:0] == 2'h0);
  endproperty
  a_enable_bits: assert property (p_enable_bits) else $error("enable write did not start clocks");

  property p_status_read;
    @(posedge pclk) disable iff (!presetn)
      (acc && paddr == `OFF_PCSR) |=> (prdata == $past(periph_clk_run)) && pready;
  endproperty
  a_status_read: assert property (p_status_read) else $error("peripheral status read wrong");

  property p_osc_interval;
    @(posedge pclk) disable iff (!presetn)
      ($rose(main_osc_stable) && !xtal_bypass) |-> (osc_ticks_q == {osc_cnt_q, 3'h0});
  endproperty
  a_osc_interval: assert property (p_osc_interval) else $error("oscillator stable before start-up time");

  property p_bypass_stable;
    @(posedge pclk) disable iff (!presetn)
      xtal_bypass |=> main_osc_stable;
  endproperty
  a_bypass_stable: assert property (p_bypass_stable) else $error("bypass did not set stable");

  property p_off_clears;
    @(posedge pclk) disable iff (!presetn)
      (!main_osc_enable && !xtal_bypass) |=> !main_osc_stable;
  endproperty
  a_off_clears: assert property (p_off_clears) else $error("stable flag stayed with oscillator off");

  property p_freq_window;
    @(posedge pclk) disable iff (!presetn)
      (meas_q == clk_ctrl_pkg::MEAS_RUN && slow_tick && win_q == `MEAS_LAST && (main_osc_enable || xtal_bypass))
        |=> valid_q && (freq_q == $past(mcount_q));
  endproperty
  a_freq_window: assert property (p_freq_window) else $error("frequency count not latched at window end");

  property p_valid_needs_osc;
    @(posedge pclk) disable iff (!presetn)
      valid_q |-> ($past(main_osc_enable) || $past(xtal_bypass)) && meas_q == clk_ctrl_pkg::MEAS_DONE;
  endproperty
  a_valid_needs_osc: assert property (p_valid_needs_osc) else $error("ready bit set without oscillator");

  property p_lock_after_write;
    @(posedge pclk) disable iff (!presetn)
      wr_pll |=> !lock_q ##1 (!lock_q || pll_q[`PLL_CNT_HI:`PLL_CNT_LO] == 6'h0);
  endproperty
  a_lock_after_write: assert property (p_lock_after_write) else $error("lock not held off after pll write");

  property p_pll_off;
    @(posedge pclk) disable iff (!presetn)
      (pll_q[`PLL_DIV_HI:`PLL_DIV_LO] == 8'h0 || pll_q[`PLL_MUL_HI:`PLL_MUL_LO] == 11'h0) |=> !pll_run;
  endproperty
  a_pll_off: assert property (p_pll_off) else $error("pll running with zero divider or multiplier");

  property p_mck_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == `OFF_MCKR) |=> (mck_source == $past(pwdata[1:0])) && (mck_clock_scaler_code == $past(pwdata[4:2]));
  endproperty
  a_mck_write: assert property (p_mck_write) else $error("master clock fields not updated");

  c_bypass: cover property (@(posedge pclk) disable iff (!presetn) $rose(xtal_bypass) ##1 main_osc_stable);
  c_osc_start: cover property (@(posedge pclk) disable iff (!presetn) $rose(main_osc_stable) && !xtal_bypass);
  c_lock: cover property (@(posedge pclk) disable iff (!presetn) $rose(lock_q));
  c_freq: cover property (@(posedge pclk) disable iff (!presetn) $rose(valid_q));
endmodule
`default_nettype wire

// ---- clk_source_model.sv ----
// far-side model: free-running slow clock and a main oscillator clock
// assumes main_run is high while the oscillator is enabled or bypassed
`timescale 1ns/100ps
`default_nettype none
module clk_source_model #(
  parameter int SLOW_HALF_NS = 40,
  parameter int MAIN_HALF_NS = 20
) (
  input  wire logic main_run,
  output logic      slow_clk,
  output logic      main_clk
);
  // slow clock runs free from time zero
  initial begin
    slow_clk = 1'b0;
    forever #(SLOW_HALF_NS) slow_clk = ~slow_clk;
  end
  // main clock toggles only while the oscillator runs, parked low otherwise
  initial begin
    main_clk = 1'b0;
    forever begin
      #(MAIN_HALF_NS);
      if (main_run === 1'b1) main_clk = ~main_clk;
      else main_clk = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench of the clock control block driven over apb
// assumes the source model makes a 16-cycle slow clock and 8-cycle main clock
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr, a;
  logic [31:0] pwdata, prdata, periph_clk_run, r, v, pe;
  logic        main_osc_enable, xtal_bypass, main_osc_stable, pll_run, slow_clk, main_clk;
  logic [7:0]  pll_in_div, dv;
  logic [10:0] pll_feedback_factor, ml;
  logic [1:0]  pll_range, usb_clock_ratio, mck_source;
  logic [2:0]  mck_clock_scaler_code;
  logic [14:0] prog_clk_cfg;
  int          n_errors, n_compared, cyc, i, n, t;
  integer      seed;
  localparam logic [11:0] reset_addr [9] = '{12'h018, 12'h020, 12'h024, 12'h02C, 12'h030,
                                             12'h040, 12'h044, 12'h048, 12'h068};
  localparam logic [31:0] reset_val [9] = '{32'h0, 32'h0, 32'h0, 32'h3F00, 32'h0, 32'h0, 32'h0, 32'h0, 32'h8};

  clock_source_pll_control_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slow_clk_in(slow_clk), .main_clk_in(main_clk), .periph_clk_run(periph_clk_run),
    .main_osc_enable(main_osc_enable), .xtal_bypass(xtal_bypass), .main_osc_stable(main_osc_stable),
    .pll_run(pll_run), .pll_in_div(pll_in_div), .pll_feedback_factor(pll_feedback_factor),
    .pll_range(pll_range), .usb_clock_ratio(usb_clock_ratio), .mck_source(mck_source),
    .mck_clock_scaler_code(mck_clock_scaler_code), .prog_clk_cfg(prog_clk_cfg));
  clk_source_model i_src (.main_run(main_osc_enable | xtal_bypass), .slow_clk(slow_clk), .main_clk(main_clk));

  // clock and cycle count
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;

  // expectation helpers
  function automatic logic in_range(input int x, input int lo, input int hi);
    return (x >= lo) && (x <= hi);
  endfunction
  function automatic logic exp_run(input logic [7:0] d, input logic [10:0] m);
    return (d != 8'h00) && (m != 11'h000);
  endfunction
  function automatic logic [1:0] src_code(input int k);
    return (k == 2) ? 2'h3 : 2'(k);
  endfunction

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) n_errors++;
    r = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic summarize();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // watchdog against a hung handshake or flag
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    summarize();
  end

  initial begin
    seed = 32'h2C8E;
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, unmapped and read-only accesses
    for (i = 0; i < 9; i++) begin
      apb(1'b0, reset_addr[i], 32'h0);
      chk("reset value", r, reset_val[i]);
    end
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped", {err, r[30:0]}, 32'h80000000);
    apb(1'b1, 12'h018, 32'hFFFFFFFF);
    apb(1'b0, 12'h018, 32'h0);
    chk("read-only status", r, 32'h0);
    // peripheral gating with random set and clear masks
    pe = 32'h0;
    for (i = 0; i < 10; i++) begin
      v = (i == 0) ? 32'hFFFFFFFF : (i == 3) ? 32'h0 : $random(seed);
      apb(1'b1, (i % 3 == 1) ? 12'h014 : 12'h010, v);
      pe = ((i % 3 == 1) ? (pe & ~v) : (pe | v)) & 32'hFFFFFFFC;
      apb(1'b0, 12'h018, 32'h0);
      chk("periph status", r, pe);
      chk("periph run", periph_clk_run, pe);
    end
    // oscillator start-up, frequency count, clear and bypass
    apb(1'b1, 12'h020, 32'h00000201);
    t = cyc;
    chk("stable early", 32'(main_osc_stable), 32'h0);
    while (main_osc_stable !== 1'b1 && cyc - t < 1000) @(posedge pclk);
    chk("startup time", 32'(in_range(cyc - t, 240, 268)), 32'h1);
    apb(1'b0, 12'h068, 32'h0);
    chk("status stable", r, 32'h9);
    n = 0;
    do begin
      apb(1'b0, 12'h024, 32'h0);
      n++;
    end while (r[16] !== 1'b1 && n < 200);
    chk("freq count", 32'(in_range(int'(r[15:0]), 31, 33)), 32'h1);
    apb(1'b1, 12'h020, 32'h0);
    repeat (2) @(posedge pclk);
    chk("stable cleared", 32'(main_osc_stable), 32'h0);
    apb(1'b0, 12'h024, 32'h0);
    chk("ready cleared", 32'(r[16]), 32'h0);
    apb(1'b1, 12'h020, 32'h2);
    repeat (2) @(posedge pclk);
    chk("bypass stable", 32'({xtal_bypass, main_osc_enable, main_osc_stable}), 32'h5);
    // pll words: divider and multiplier corners, usb ratios, lock timing
    for (i = 0; i < 4; i++) begin
      dv = (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : 8'($random(seed));
      ml = (i == 1) ? 11'h000 : (i == 3) ? 11'h7FF : 11'($random(seed));
      // settle of two or more ticks, so a tick right after the write cannot lock before the first read
      v = {2'h0, 2'(i % 3), 1'h0, ml, 2'($random(seed)), 6'(i + 2), dv};
      apb(1'b1, 12'h02C, v);
      t = cyc;
      apb(1'b0, 12'h068, 32'h0);
      chk("lock cleared", 32'(r[2]), 32'h0);
      apb(1'b0, 12'h02C, 32'h0);
      chk("pll readback", r, v);
      chk("pll fields", 32'({usb_clock_ratio, pll_feedback_factor, pll_range, pll_in_div}),
          32'({v[29:28], v[26:16], v[15:14], v[7:0]}));
      chk("pll run", 32'(pll_run), 32'(exp_run(dv, ml)));
      n = 0;
      do begin
        apb(1'b0, 12'h068, 32'h0);
        n++;
      end while (r[2] !== 1'b1 && n < 100);
      chk("lock time", 32'(in_range(cyc - t, (i + 1) * 16, (i + 1) * 16 + 40)), 32'h1);
    end
    // master and programmable output clock words
    for (i = 0; i < 10; i++) begin
      v = {27'h0, (i < 7) ? 3'(i) : 3'($unsigned($random(seed)) % 7), src_code(i % 3)};
      a = (i < 7) ? 12'h030 : 12'h040 + 12'(4 * (i - 7));
      apb(1'b1, a, v);
      apb(1'b0, a, 32'h0);
      chk("clock word", r, v);
      if (i < 7) chk("master ports", 32'({mck_clock_scaler_code, mck_source}), v);
      else chk("output cfg", 32'(prog_clk_cfg[5 * (i - 7) +: 5]), v);
    end
    summarize();
  end
endmodule
`default_nettype wire
